/* File: rtl/ipm_host.v */
`timescale 1ns/1ps
`include "ipm_map.vh"
module ipm_host (
    core_clk,
    reset_n,
    req_valid,
    req_read,
    req_addr,
    req_wdata,
    req_ready,
    done,
    nack,
    rdata,
    scl_in,
    scl_out,
    scl_oe_n,
    sda_in,
    sda_out,
    sda_oe_n
);
    input  wire        core_clk;
    input  wire        reset_n;
    input  wire        req_valid;
    input  wire        req_read;
    input  wire [15:0] req_addr;
    input  wire [31:0] req_wdata;
    output reg         req_ready;
    output reg         done;
    output reg         nack;
    output reg  [31:0] rdata;
    input  wire        scl_in;
    output reg         scl_out;
    output reg         scl_oe_n;
    input  wire        sda_in;
    output reg         sda_out;
    output reg         sda_oe_n;

    // ==========================================================
    // States
    localparam ST_IDLE  = 3'h0;
    localparam ST_START = 3'h1;
    localparam ST_BIT   = 3'h2;
    localparam ST_ACK   = 3'h3;
    localparam ST_RSTRT = 3'h4;
    localparam ST_STOP  = 3'h5;

    // Quarter of a 400 kHz bit at 40 MHz: 25 cycles
    localparam [`IPM_QTR_W-1:0] QTR_LAST = `IPM_QTR_LAST;

    // ==========================================================
    // Pin synchronisers
    reg        sda_s1_reg;
    reg        sda_s2_reg;
    reg        scl_s1_reg;
    reg        scl_s2_reg;

    always @(posedge core_clk) begin
        if (!reset_n) begin
            sda_s1_reg <= 1'b1;
            sda_s2_reg <= 1'b1;
            scl_s1_reg <= 1'b1;
            scl_s2_reg <= 1'b1;
        end else begin
            sda_s1_reg <= sda_in;
            sda_s2_reg <= sda_s1_reg;
            scl_s1_reg <= scl_in;
            scl_s2_reg <= scl_s1_reg;
        end
    end

    // ==========================================================
    // Quarter-period tick
    reg  [`IPM_QTR_W-1:0] qcnt_reg;
    wire                  tick;
    // RL13: no faster than 400 kHz
    assign tick = (qcnt_reg == QTR_LAST);

    // ==========================================================
    // Transaction engine
    reg  [2:0]  state_reg;
    reg  [1:0]  phase_reg;
    reg  [2:0]  bit_reg;
    reg  [3:0]  byte_reg;
    reg  [3:0]  total_reg;
    reg  [7:0]  shift_reg;
    reg         rd_reg;
    reg         rx_reg;
    reg  [15:0] addr_reg;
    reg  [31:0] wdata_reg;

    // Byte to send for a given index; reads resend address with direction one
    function [7:0] tx_byte;
        input [3:0]  idx;
        input        rd;
        input [15:0] a;
        input [31:0] d;
        begin
            case (idx)
                4'h0: tx_byte = {`IPM_DEV_ADDR, 1'b0};
                4'h1: tx_byte = a[15:8];
                4'h2: tx_byte = a[7:0];
                4'h3: tx_byte = rd ? {`IPM_DEV_ADDR, 1'b1} : d[7:0];
                4'h4: tx_byte = d[15:8];
                4'h5: tx_byte = d[23:16];
                4'h6: tx_byte = d[31:24];
                default: tx_byte = 8'hFF;
            endcase
        end
    endfunction

    always @(posedge core_clk) begin
        if (!reset_n) begin
            qcnt_reg  <= {`IPM_QTR_W{1'b0}};
            state_reg <= ST_IDLE;
            phase_reg <= 2'h0;
            bit_reg   <= 3'h0;
            byte_reg  <= 4'h0;
            total_reg <= 4'h0;
            shift_reg <= 8'h00;
            rd_reg    <= 1'b0;
            rx_reg    <= 1'b0;
            addr_reg  <= 16'h0000;
            wdata_reg <= 32'h0000_0000;
            req_ready <= 1'b1;
            done      <= 1'b0;
            nack      <= 1'b0;
            rdata     <= 32'h0000_0000;
            scl_out   <= 1'b0;
            scl_oe_n  <= 1'b1;
            sda_out   <= 1'b0;
            sda_oe_n  <= 1'b1;
        end else begin
            done <= 1'b0;
            if (state_reg == ST_IDLE) begin
                qcnt_reg <= {`IPM_QTR_W{1'b0}};
                if (req_valid) begin
                    state_reg <= ST_START;
                    req_ready <= 1'b0;
                    nack      <= 1'b0;
                    rd_reg    <= req_read;
                    addr_reg  <= req_addr;
                    wdata_reg <= req_wdata;
                    byte_reg  <= 4'h0;
                    phase_reg <= 2'h0;
                    rx_reg    <= 1'b0;
                    // RL2: seven-byte write, cut short only when the device refuses a byte
                    total_reg <= req_read ? `IPM_BYTES_RD1 : `IPM_BYTES_W;
                end
            end else if (!tick) begin
                qcnt_reg <= qcnt_reg + 1'b1;
            // Clock stretching: wait while the released clock reads low
            end else if (phase_reg == 2'h2 && scl_oe_n && !scl_s2_reg) begin
                qcnt_reg <= qcnt_reg;
            end else begin
                qcnt_reg  <= {`IPM_QTR_W{1'b0}};
                phase_reg <= phase_reg + 2'h1;
                case (state_reg)
                    ST_START, ST_RSTRT: begin
                        // RL5: open with START
                        // RL6: data falls while clock high
                        case (phase_reg)
                            2'h0: sda_oe_n <= 1'b1;
                            2'h1: scl_oe_n <= 1'b1;
                            2'h2: sda_oe_n <= 1'b0;
                            default: begin
                                // RL14: pull low only
                                scl_oe_n  <= 1'b0;
                                state_reg <= ST_BIT;
                                bit_reg   <= 3'h0;
                                shift_reg <= tx_byte(byte_reg, rd_reg, addr_reg, wdata_reg);
                            end
                        endcase
                    end
                    ST_BIT: begin
                        case (phase_reg)
                            // RL7: MSB first
                            // RL8: data changes only while clock low
                            2'h0: sda_oe_n <= rx_reg | shift_reg[7];
                            2'h1: scl_oe_n <= 1'b1;
                            2'h2: begin
                                if (rx_reg)
                                    shift_reg <= {shift_reg[6:0], sda_s2_reg};
                                else
                                    shift_reg <= {shift_reg[6:0], 1'b0};
                            end
                            default: begin
                                scl_oe_n <= 1'b0;
                                if (bit_reg == `IPM_BIT_LAST)
                                    state_reg <= ST_ACK;
                                bit_reg <= bit_reg + 3'h1;
                            end
                        endcase
                    end
                    ST_ACK: begin
                        case (phase_reg)
                            // RL9: release data for device acknowledge
                            // RL3: one pulse, receiver drives it; host acks all but last read byte
                            2'h0: sda_oe_n <= rx_reg ? (byte_reg == total_reg - 4'h1) : 1'b1;
                            2'h1: scl_oe_n <= 1'b1;
                            2'h2: begin
                                if (rx_reg) begin
                                    // RL16: data low byte first
                                    rdata <= {shift_reg, rdata[31:8]};
                                end else if (sda_s2_reg) begin
                                    nack <= 1'b1;
                                end
                            end
                            default: begin
                                scl_oe_n <= 1'b0;
                                byte_reg <= byte_reg + 4'h1;
                                bit_reg  <= 3'h0;
                                if (!rx_reg && sda_s2_reg) begin
                                    // RL4: abandon on refusal, no partial write continues
                                    state_reg <= ST_STOP;
                                end else if (byte_reg == total_reg - 4'h1) begin
                                    if (rd_reg && total_reg == `IPM_BYTES_RD1) begin
                                        // RL16: repeated START after address
                                        state_reg <= ST_RSTRT;
                                        total_reg <= `IPM_BYTES_RD2;
                                    end else if (rd_reg && !rx_reg) begin
                                        rx_reg    <= 1'b1;
                                        total_reg <= `IPM_BYTES_RD;
                                        state_reg <= ST_BIT;
                                    end else begin
                                        state_reg <= ST_STOP;
                                    end
                                end else begin
                                    // RL10: upper then lower address byte
                                    // RL11: data bytes 7:0 up to 31:24
                                    state_reg <= ST_BIT;
                                    shift_reg <= tx_byte(byte_reg + 4'h1, rd_reg, addr_reg, wdata_reg);
                                end
                            end
                        endcase
                    end
                    ST_STOP: begin
                        // RL12: data rises while clock high
                        case (phase_reg)
                            2'h0: sda_oe_n <= 1'b0;
                            2'h1: scl_oe_n <= 1'b1;
                            2'h2: sda_oe_n <= 1'b1;
                            default: begin
                                state_reg <= ST_IDLE;
                                req_ready <= 1'b1;
                                done      <= 1'b1;
                            end
                        endcase
                    end
                    default: state_reg <= ST_IDLE;
                endcase
            end
        end
    end
endmodule

/* File: rtl/ipm_map.vh */
// Contract
// RL1: The device answers only to seven-bit address 0110000, the eighth bit giving direction.
// RL2: A register write is seven bytes: device address, two register address bytes, four data bytes.
// RL3: Each byte is followed by one acknowledge clock pulse driven by the receiver.
// RL4: The device ignores read or write commands with only one data byte and keeps its registers.
// RL5: The master opens each transaction with START and closes it with STOP.
// RL6: START is data falling while clock is high, telling all devices an address follows.
// RL7: The master sends the seven-bit address MSB first, then the direction bit, zero for write.
// RL8: Bits are sampled on the rising clock edge and held stable through the whole clock high phase.
// RL9: The master releases data after the direction bit; a matching device pulls it low for acknowledge.
// RL10: The register address goes upper byte then lower byte, each MSB first and acknowledged.
// RL11: Register data goes as bytes 7:0, 15:8, 23:16, 31:24, each MSB first, next only after acknowledge.
// RL12: After the acknowledge of byte 31:24 the master ends with STOP, data rising while clock is high.
// RL13: The master never runs the serial clock faster than 400 kHz.
// RL14: Both lines are open drain; each party only pulls low or releases.
// RL15: The device can transmit, receive and itself act as master generating the clock.
// RL16: A read writes the two address bytes, repeated START, address with direction one, then four data bytes low first.
// RL17: The device updates the register only after all four data bytes are received and acknowledged.
`ifndef IPM_MAP_VH
`define IPM_MAP_VH
`define IPM_DEV_ADDR      7'h30
`define IPM_CLK_HZ        40000000
`define IPM_SCL_HZ        400000
`define IPM_QTR_CYC       ((`IPM_CLK_HZ + 4 * `IPM_SCL_HZ - 1) / (4 * `IPM_SCL_HZ))
`define IPM_QTR_W         5
`define IPM_QTR_LAST      5'h18
`define IPM_BYTES_W       4'h7
`define IPM_BYTES_RD1     4'h3
`define IPM_BYTES_RD2     4'h4
`define IPM_BYTES_RD      4'h8
`define IPM_BIT_LAST      3'h7
`endif

/* File: tb/ipm_host_assertions.sv */
`timescale 1ns/1ps
// ============================================
// Host pin and handshake checks
module ipm_host_chk (
    input wire core_clk,
    input wire reset_n,
    input wire req_valid,
    input wire req_ready,
    input wire done,
    input wire nack,
    input wire scl_out,
    input wire sda_out,
    input wire scl_oe_n,
    input wire sda_oe_n
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    sequence s_take;  req_valid && req_ready; endsequence
    sequence s_start; $fell(sda_oe_n) && scl_oe_n; endsequence
    property p_low_only; !scl_out && !sda_out; endproperty
    a_low_only: assert property (p_low_only) else $error("line driven high");
    property p_idle_rel; req_ready |-> scl_oe_n && sda_oe_n; endproperty
    a_idle_rel: assert property (p_idle_rel) else $error("line held while idle");
    property p_open; s_take |-> ##[1:200] s_start; endproperty
    a_open: assert property (p_open) else $error("no start after request");
    property p_busy; s_take |=> !req_ready; endproperty
    a_busy: assert property (p_busy) else $error("ready while busy");
    property p_stop; done |-> sda_oe_n && scl_oe_n; endproperty
    a_stop: assert property (p_stop) else $error("done without stop");
    property p_done_once; done |-> req_ready ##1 !done; endproperty
    a_done_once: assert property (p_done_once) else $error("done not a single pulse");
    property p_nack_clr; s_take |=> !nack; endproperty
    a_nack_clr: assert property (p_nack_clr) else $error("refusal flag kept");
    property p_clk_high; $rose(scl_oe_n) |-> scl_oe_n[*8]; endproperty
    a_clk_high: assert property (p_clk_high) else $error("clock high too short");
    property p_clk_low; $fell(scl_oe_n) |-> !scl_oe_n[*8]; endproperty
    a_clk_low: assert property (p_clk_low) else $error("clock low too short");
endmodule

/* File: tb/ipm_dev.sv */
`timescale 1ns/1ps
`include "ipm_map.vh"
// ============================================
// Page-mode register device
module ipm_dev (
    input  wire scl,
    input  wire sda,
    input  wire refuse,
    input  wire slow,
    output reg  pull,
    output reg  hold
);
    reg [31:0] mem [0:3];
    reg [31:0] wd, rs;
    reg [15:0] ra;
    reg [7:0]  sr;
    reg [3:0]  bc, by;
    reg        act, tx, nak;
    initial begin
        pull = 0;
        hold = 0;
        act = 0;
        tx = 0;
        for (by = 0; by < 4; by = by + 1) mem[by] = 32'h0;
    end
    always @(negedge sda) if (scl === 1'b1) begin
        act = 1;
        tx = 0;
        // Clock fall ending START is not a data bit
        bc = 8;
        by = 0;
    end
    always @(posedge sda) if (scl === 1'b1) begin
        if (act && !tx && by == 7) mem[ra[1:0]] = wd;
        act = 0;
    end
    always @(posedge scl) if (act) begin
        if (bc == 8) nak = sda;
        else sr = {sr[6:0], sda};
    end
    always @(negedge scl) if (act) begin
        pull = 0;
        if (bc == 8) begin
            bc = 0;
            if (tx && nak) act = 0;
            else if (tx) pull = !rs[7];
        end else if (bc == 7) begin
            bc = 8;
            if (tx) rs = rs >> 8;
            else begin
                pull = (by == 0) ? (sr[7:1] == `IPM_DEV_ADDR) : !refuse;
                if (by == 0) tx = sr[0];
                if (by == 0) rs = mem[ra[1:0]];
                if (by == 1 || by == 2) ra = {ra[7:0], sr};
                if (by > 2) wd = {sr, wd[31:8]};
                by = by + 1;
                if (!pull) act = 0;
            end
            // Stretch the ack clock when asked
            if (slow) begin
                hold = 1;
                #3000 hold = 0;
            end
        end else begin
            bc = bc + 1;
            if (tx) pull = !rs[7 - bc];
        end
    end
endmodule

/* File: tb/ipm_host_tb.sv */
`timescale 1ns/1ps
// ============================================
// Host controller bench
module ipm_host_tb;
    reg         core_clk, reset_n, req_valid, req_read, refuse, slow;
    reg  [15:0] req_addr;
    reg  [31:0] req_wdata;
    wire        req_ready, done, nack, scl_out, scl_oe_n, sda_out, sda_oe_n, pull, hold;
    wire [31:0] rdata;
    wire        scl = ~(~scl_oe_n | hold);
    wire        sda = ~(~sda_oe_n | pull);
    integer     err_total, tests_run, cyc;
    ipm_host dut_u (.core_clk(core_clk), .reset_n(reset_n), .req_valid(req_valid), .req_read(req_read),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready), .done(done), .nack(nack),
        .rdata(rdata), .scl_in(scl), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n));
    ipm_dev dev_u (.scl(scl), .sda(sda), .refuse(refuse), .slow(slow), .pull(pull), .hold(hold));
    always #12.5 core_clk = ~core_clk;
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task tally_and_finish;
        begin
            if (err_total == 0 && tests_run > 0) $display("All tests passed");
            else $display("Some tests failed");
            $finish;
        end
    endtask
    // Called just after an edge with the host idle
    task op(input rd, input [15:0] a, input [31:0] d);
        integer n;
        begin
            req_valid = 1;
            req_read = rd;
            req_addr = a;
            req_wdata = d;
            @(posedge core_clk) #1;
            req_valid = 0;
            n = 0;
            while (done !== 1'b1 && n < 20000) begin
                @(posedge core_clk) #1;
                n = n + 1;
            end
            chk(n < 20000, 1);
        end
    endtask
    task sc_write_read;
        begin
            op(0, 16'h0501, 32'h31E4FFAA);
            chk(dev_u.mem[1], 32'h31E4FFAA);
            chk(dev_u.ra, 16'h0501);
            chk(nack, 0);
            op(1, 16'h0501, 32'h0);
            chk(rdata, 32'h31E4FFAA);
        end
    endtask
    task sc_back_to_back;
        begin
            op(0, 16'h0502, 32'h01234567);
            op(0, 16'h0503, 32'h89ABCDEF);
            chk(dev_u.mem[2], 32'h01234567);
            chk(dev_u.mem[3], 32'h89ABCDEF);
            op(1, 16'h0503, 32'h0);
            chk(rdata, 32'h89ABCDEF);
        end
    endtask
    task sc_refused;
        begin
            refuse = 1;
            op(0, 16'h0500, 32'hDEADBEEF);
            chk(nack, 1);
            chk(dev_u.mem[0], 32'h0);
            refuse = 0;
            op(0, 16'h0500, 32'h5A5AA5A5);
            chk(nack, 0);
            chk(dev_u.mem[0], 32'h5A5AA5A5);
        end
    endtask
    task sc_stretched;
        begin
            slow = 1;
            op(0, 16'h0501, 32'h0F0FF0F0);
            slow = 0;
            chk(dev_u.mem[1], 32'h0F0FF0F0);
        end
    endtask
    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (cyc == 90000) begin
            err_total = err_total + 1;
            tally_and_finish;
        end
    end
    initial begin
        core_clk = 0;
        reset_n = 0;
        req_valid = 0;
        req_read = 0;
        req_addr = 16'h0;
        req_wdata = 32'h0;
        refuse = 0;
        slow = 0;
        err_total = 0;
        tests_run = 0;
        cyc = 0;
        repeat (3) @(posedge core_clk);
        #1 reset_n = 1;
        chk({req_ready, done, nack, scl_oe_n, sda_oe_n}, 5'h13);
        chk(rdata, 32'h0);
        @(posedge core_clk) #1;
        sc_write_read;
        sc_back_to_back;
        sc_refused;
        sc_stretched;
        tally_and_finish;
    end
endmodule
bind ipm_host ipm_host_chk chk_u (.core_clk(core_clk), .reset_n(reset_n), .req_valid(req_valid),
    .req_ready(req_ready), .done(done), .nack(nack), .scl_out(scl_out), .sda_out(sda_out),
    .scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n));
